// ---- sebg_pkg.sv ----
// Functional notes
// - error request flag sets in the same cycle as the receive request flag.
// - async only, framing check on: any low stop bit sets the framing flag.
// - async parity mode (A8P only), parity check on: wrong parity bit sets the parity flag.
// - overrun check on: frame completes while buffer unread sets the overrun flag.
// - baud timer is a dedicated 13-bit counter advanced every second clock.
// - baud timer counts down only while the run bit is set.
// - each underflow reloads from the reload register; with prescale select zero it also gives one baud pulse.
// - prescale select one cuts the pulse rate to two thirds.
// - reading the baud register returns the count, bits 31 to 13 zero.
// - writing the baud register updates the reload register from bits 12 to 0.
// - a baud register write with run set also loads the timer.
// - a write with run clear loads the timer on the first cycle run is set.
// - async pulses run at sixteen per bit; samples 7, 8, 9 decide the bit.
// - async bit rate is clock over 16, (2 plus prescale), (reload plus 1).
// - sync pulses run at four per bit.
// - framing, parity and overrun flags stay set until software clears them.
`default_nettype none
package sebg_pkg;
  localparam logic [4:0] SEBG_OFS_CTRL = 5'h00;
  localparam logic [4:0] SEBG_OFS_BAUD = 5'h04;
  localparam logic [4:0] SEBG_OFS_STAT = 5'h08;
  localparam logic [4:0] SEBG_OFS_MASK = 5'h0C;
  localparam logic [4:0] SEBG_OFS_RXD = 5'h10;
  localparam int SEBG_TMR_W = 13;
  localparam int SEBG_CTRL_W = 10;
  localparam int SEBG_EVT_W = 5;
  localparam logic [12:0] SEBG_TMR_ZERO = 13'h0000;
  localparam logic [1:0] SEBG_PRE_LAST = 2'h2;
  localparam logic [3:0] SEBG_SAMP_A = 4'h6;
  localparam logic [3:0] SEBG_SAMP_B = 4'h7;
  localparam logic [3:0] SEBG_SAMP_C = 4'h8;
  localparam logic [3:0] SEBG_OS_LAST = 4'hF;
  localparam logic [1:0] SEBG_SY_RISE = 2'h1;
  localparam logic [1:0] SEBG_SY_LAST = 2'h3;
  localparam logic [3:0] SEBG_LAST8 = 4'h7;
  localparam logic [3:0] SEBG_LAST9 = 4'h8;
  localparam logic [1:0] SEBG_RESP_OK = 2'h0;
  localparam logic [1:0] SEBG_RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    SEBG_MODE_SYNC = 2'b00,
    SEBG_MODE_A8 = 2'b01,
    SEBG_MODE_A8P = 2'b10,
    SEBG_MODE_A9 = 2'b11
  } sebg_mode_t;

  typedef enum logic [2:0] {
    SEBG_RX_IDLE = 3'b000,
    SEBG_RX_START = 3'b001,
    SEBG_RX_DATA = 3'b010,
    SEBG_RX_STOP = 3'b011,
    SEBG_RX_SYNC = 3'b100
  } sebg_rx_st_t;

  // bit 0 is baud_run_bit
  typedef struct packed {
    logic stop2;
    logic odd;
    sebg_mode_t mode;
    logic rx_en;
    logic overrun_check_en;
    logic parity_check_en;
    logic framing_check_en;
    logic baud_prescale_sel;
    logic baud_run_bit;
  } sebg_ctrl_t;

  // bit 0 is rx_req_flag
  typedef struct packed {
    logic overrun_err_flag;
    logic parity_err_flag;
    logic framing_err_flag;
    logic error_req_flag;
    logic rx_req_flag;
  } sebg_evt_t;

  typedef struct packed {
    logic done;
    logic async;
    logic has_par;
    logic stop_ok;
    logic par_ok;
    logic was_full;
    logic fen;
    logic pen;
    logic oen;
  } sebg_frame_t;
endpackage : sebg_pkg
`default_nettype wire

// ---- sebg_err_check.sv ----
`timescale 1ns/1ps
`default_nettype none
module sebg_err_check
  import sebg_pkg::*;
(
  input wire sebg_frame_t frame,
  output var sebg_evt_t set
);
  // enables were captured with the frame, so a late control write cannot split the pair
  always_comb
  begin
    set = '0;
    set.rx_req_flag = frame.done;
    set.framing_err_flag = frame.done && frame.fen && frame.async && !frame.stop_ok;
    set.parity_err_flag = frame.done && frame.pen && frame.has_par && !frame.par_ok;
    set.overrun_err_flag = frame.done && frame.oen && frame.was_full;
    set.error_req_flag = set.framing_err_flag || set.parity_err_flag || set.overrun_err_flag;
  end
endmodule : sebg_err_check
`default_nettype wire

// ---- sebg_baud_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module sebg_baud_gen
  import sebg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic brs,
  input wire logic wr,
  input wire logic [12:0] wr_val,
  output logic tick,
  output logic [12:0] count,
  output logic [12:0] reload
);
  typedef struct packed {
    logic half;
    logic pend;
    logic [1:0] pre;
    logic tick;
    logic [12:0] cnt;
    logic [12:0] rld;
  } sebg_bg_st_t;

  sebg_bg_st_t s;
  sebg_bg_st_t n;
  logic uflow;

  // pulse period is (2 + brs) * (reload + 1) clocks on average
  always_comb
  begin
    n = s;
    n.tick = 1'h0;
    uflow = 1'h0;
    n.half = run ? ~s.half : s.half;
    if (wr)
    begin
      n.rld = wr_val;
      if (run)
      begin
        n.cnt = wr_val;
        n.pend = 1'h0;
      end
      else
        n.pend = 1'h1;
    end
    else if (run && s.pend)
    begin
      n.cnt = s.rld;
      n.pend = 1'h0;
    end
    else if (run && s.half)
    begin
      if (s.cnt == SEBG_TMR_ZERO)
      begin
        n.cnt = s.rld;
        uflow = 1'h1;
      end
      else
        n.cnt = s.cnt - 13'h0001;
    end
    if (uflow)
    begin
      // dropping one pulse in three keeps the average exact at the cost of jitter
      if (brs)
      begin
        n.pre = (s.pre == SEBG_PRE_LAST) ? 2'h0 : s.pre + 2'h1;
        n.tick = (s.pre != SEBG_PRE_LAST);
      end
      else
        n.tick = 1'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= n;
  end

  assign tick = s.tick;
  assign count = s.cnt;
  assign reload = s.rld;

  default clocking bg_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  stop_hold_a: assert property (!run |=> $stable(s.cnt) && !s.tick)
    else $error("baud timer moved while stopped");
  half_rate_a: assert property ((run && !s.half && !wr && !s.pend) |=> $stable(s.cnt))
    else $error("baud timer advanced on an off cycle");
  reload_a: assert property ((run && s.half && !wr && !s.pend && s.cnt == SEBG_TMR_ZERO) |=> s.cnt == $past(s.rld))
    else $error("underflow did not reload");
  wr_load_a: assert property ((wr && run) |=> (s.cnt == $past(wr_val)) && (s.rld == $past(wr_val)))
    else $error("running write did not load timer");
  pend_load_a: assert property ((wr && !run) ##1 (run && !wr) |=> s.cnt == $past(s.rld))
    else $error("postponed load missed");
  pre_drop_a: assert property ((brs && uflow && s.pre == SEBG_PRE_LAST) |=> !s.tick)
    else $error("prescale did not drop pulse");
endmodule : sebg_baud_gen
`default_nettype wire

// ---- sebg_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sebg_top
  import sebg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxd_in,
  output logic shift_clk_out,
  output logic irq
);
  typedef struct packed {
    sebg_ctrl_t ctrl;
    sebg_evt_t status;
    sebg_evt_t mask;
    sebg_frame_t frm;
    logic [1:0] rx_sync;
    logic rx_prev;
    sebg_rx_st_t st;
    logic [3:0] os;
    logic [3:0] bit_idx;
    logic [1:0] smp;
    logic stop_n;
    logic stop_ok;
    logic [8:0] shreg;
    logic [8:0] rbuf;
    logic full;
    logic sclk_low;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } sebg_top_st_t;

  sebg_top_st_t s;
  sebg_top_st_t n;
  sebg_evt_t evt_set;
  sebg_evt_t clr;
  logic wr_go;
  logic rd_go;
  logic bg_wr;
  logic [12:0] bg_val;
  logic bg_tick;
  logic [12:0] bg_count;
  logic [12:0] bg_reload;
  logic rd_rxd;
  logic rx_now;
  logic maj;
  logic fin;
  logic fin_stop;
  logic par_ok;
  logic [3:0] last_idx;
  logic [31:0] merged;

  function automatic logic [31:0] sebg_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] m;
    for (int i = 0; i < 4; i++)
      m[8*i +: 8] = {8{st[i]}};
    return (old & ~m) | (wd & m);
  endfunction : sebg_merge

  sebg_baud_gen u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s.ctrl.baud_run_bit),
    .brs(s.ctrl.baud_prescale_sel),
    .wr(bg_wr),
    .wr_val(bg_val),
    .tick(bg_tick),
    .count(bg_count),
    .reload(bg_reload)
  );

  sebg_err_check u_err (
    .frame(s.frm),
    .set(evt_set)
  );

  // one write and one read in flight; the response slot gates the next request
  assign wr_go = awvalid && wvalid && !s.bvalid;
  assign rd_go = arvalid && !s.rvalid;

  always_comb
  begin
    n = s;
    clr = '0;
    bg_wr = 1'h0;
    bg_val = bg_reload;
    rd_rxd = 1'h0;
    merged = 32'h0;
    fin = 1'h0;
    fin_stop = 1'h1;
    rx_now = s.rx_sync[1];
    maj = (s.smp[1] & s.smp[0]) | (s.smp[1] & rx_now) | (s.smp[0] & rx_now);
    par_ok = (s.shreg[8] == (^s.shreg[7:0] ^ s.ctrl.odd));
    last_idx = (s.ctrl.mode == SEBG_MODE_A8 || s.ctrl.mode == SEBG_MODE_SYNC) ? SEBG_LAST8 : SEBG_LAST9;

    if (s.bvalid && bready)
      n.bvalid = 1'h0;
    if (s.rvalid && rready)
      n.rvalid = 1'h0;

    if (wr_go)
    begin
      n.bvalid = 1'h1;
      n.bresp = SEBG_RESP_OK;
      case ({awaddr[4:2], 2'h0})
        SEBG_OFS_CTRL:
        begin
          merged = sebg_merge({22'h0, s.ctrl}, wdata, wstrb);
          n.ctrl = sebg_ctrl_t'(merged[SEBG_CTRL_W-1:0]);
        end
        SEBG_OFS_BAUD:
        begin
          merged = sebg_merge({19'h0, bg_reload}, wdata, wstrb);
          bg_wr = 1'h1;
          bg_val = merged[SEBG_TMR_W-1:0];
        end
        SEBG_OFS_STAT:
        begin
          merged = sebg_merge(32'h0, wdata, wstrb);
          clr = sebg_evt_t'(merged[SEBG_EVT_W-1:0]);
        end
        SEBG_OFS_MASK:
        begin
          merged = sebg_merge({27'h0, s.mask}, wdata, wstrb);
          n.mask = sebg_evt_t'(merged[SEBG_EVT_W-1:0]);
        end
        default: n.bresp = SEBG_RESP_ERR;
      endcase
    end

    if (rd_go)
    begin
      n.rvalid = 1'h1;
      n.rresp = SEBG_RESP_OK;
      n.rdata = 32'h0;
      case ({araddr[4:2], 2'h0})
        SEBG_OFS_CTRL: n.rdata = {22'h0, s.ctrl};
        SEBG_OFS_BAUD: n.rdata = {19'h0, bg_count};
        SEBG_OFS_STAT: n.rdata = {27'h0, s.status};
        SEBG_OFS_MASK: n.rdata = {27'h0, s.mask};
        SEBG_OFS_RXD:
        begin
          n.rdata = {22'h0, s.full, s.rbuf};
          rd_rxd = 1'h1;
          n.full = 1'h0;
        end
        default: n.rresp = SEBG_RESP_ERR;
      endcase
    end

    // hardware set wins over a same-cycle software clear
    n.status = (s.status & ~clr) | evt_set;

    n.rx_sync = {s.rx_sync[0], rxd_in};
    n.rx_prev = rx_now;
    n.frm = '0;

    case (s.st)
      SEBG_RX_IDLE:
      begin
        if (s.ctrl.baud_run_bit && s.ctrl.rx_en)
        begin
          n.os = 4'h0;
          n.bit_idx = 4'h0;
          n.shreg = 9'h000;
          if (s.ctrl.mode == SEBG_MODE_SYNC)
          begin
            n.st = SEBG_RX_SYNC;
            n.sclk_low = 1'h1;
          end
          else if (s.rx_prev && !rx_now)
            n.st = SEBG_RX_START;
        end
      end
      SEBG_RX_START, SEBG_RX_DATA, SEBG_RX_STOP:
      begin
        if (bg_tick)
        begin
          n.os = s.os + 4'h1;
          if (s.os == SEBG_SAMP_A || s.os == SEBG_SAMP_B)
            n.smp = {s.smp[0], rx_now};
          if (s.os == SEBG_SAMP_C)
          begin
            if (s.st == SEBG_RX_START)
            begin
              // a start bit that votes high was noise; wait for the next edge
              if (maj)
                n.st = SEBG_RX_IDLE;
            end
            else if (s.st == SEBG_RX_DATA)
              n.shreg[s.bit_idx] = maj;
            else
            begin
              n.stop_ok = s.stop_ok & maj;
              if (s.stop_n == s.ctrl.stop2)
              begin
                n.st = SEBG_RX_IDLE;
                fin = 1'h1;
                fin_stop = s.stop_ok & maj;
              end
            end
          end
          if (s.os == SEBG_OS_LAST)
          begin
            if (s.st == SEBG_RX_START)
            begin
              n.st = SEBG_RX_DATA;
              n.bit_idx = 4'h0;
            end
            else if (s.st == SEBG_RX_DATA)
            begin
              if (s.bit_idx == last_idx)
              begin
                n.st = SEBG_RX_STOP;
                n.stop_n = 1'h0;
                n.stop_ok = 1'h1;
              end
              else
                n.bit_idx = s.bit_idx + 4'h1;
            end
            else
              n.stop_n = 1'h1;
          end
        end
      end
      SEBG_RX_SYNC:
      begin
        if (bg_tick)
        begin
          n.os = s.os + 4'h1;
          if (s.os[1:0] == SEBG_SY_RISE)
          begin
            n.sclk_low = 1'h0;
            n.shreg[s.bit_idx] = rx_now;
          end
          else if (s.os[1:0] == SEBG_SY_LAST)
          begin
            if (s.bit_idx == SEBG_LAST8)
            begin
              n.st = SEBG_RX_IDLE;
              n.ctrl.rx_en = 1'h0;
              fin = 1'h1;
            end
            else
            begin
              n.sclk_low = 1'h1;
              n.bit_idx = s.bit_idx + 4'h1;
            end
          end
        end
      end
      default: n.st = SEBG_RX_IDLE;
    endcase

    if (fin)
    begin
      n.rbuf = s.shreg;
      n.full = 1'h1;
      n.frm.done = 1'h1;
      n.frm.async = (s.ctrl.mode != SEBG_MODE_SYNC);
      n.frm.has_par = (s.ctrl.mode == SEBG_MODE_A8P);
      n.frm.stop_ok = fin_stop;
      n.frm.par_ok = par_ok;
      n.frm.was_full = s.full && !rd_rxd;
      n.frm.fen = s.ctrl.framing_check_en;
      n.frm.pen = s.ctrl.parity_check_en;
      n.frm.oen = s.ctrl.overrun_check_en;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= n;
  end

  assign awready = wr_go;
  assign wready = wr_go;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = rd_go;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign shift_clk_out = ~s.sclk_low;
  assign irq = |(s.status & s.mask);

  default clocking top_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  err_rx_pair_a: assert property (evt_set.error_req_flag |=> s.status.error_req_flag && s.status.rx_req_flag)
    else $error("error request without receive request");
  fe_sync_a: assert property ((fin && s.ctrl.mode == SEBG_MODE_SYNC) |=> !evt_set.framing_err_flag)
    else $error("framing error in sync mode");
  pe_mode_a: assert property ((fin && s.ctrl.mode != SEBG_MODE_A8P) |=> !evt_set.parity_err_flag)
    else $error("parity error outside parity mode");
  ovr_set_a: assert property ((fin && s.full && !rd_rxd && s.ctrl.overrun_check_en) |=> evt_set.overrun_err_flag && evt_set.error_req_flag)
    else $error("overrun not flagged");
  chk_off_a: assert property ((fin && !s.ctrl.framing_check_en && !s.ctrl.parity_check_en && !s.ctrl.overrun_check_en) |=> !evt_set.error_req_flag)
    else $error("error raised by disabled check");
  flag_hold_a: assert property ((s.status.framing_err_flag && !clr.framing_err_flag) |=> s.status.framing_err_flag)
    else $error("framing flag dropped without clear");
  async_samp_a: assert property ((fin && s.st != SEBG_RX_SYNC) |-> bg_tick && s.os == SEBG_SAMP_C)
    else $error("async frame ended off the ninth sample");
  sync_edge_a: assert property ((fin && s.st == SEBG_RX_SYNC) |-> s.os[1:0] == SEBG_SY_LAST)
    else $error("sync frame ended off its fourth pulse");
  baud_read_a: assert property ((rd_go && {araddr[4:2], 2'h0} == SEBG_OFS_BAUD) |=> s.rdata == {19'h0, $past(bg_count)})
    else $error("baud read returned wrong value");
endmodule : sebg_top
`default_nettype wire

// ---- sebg_rx_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module sebg_rx_peer
(
  input wire logic aclk,
  input wire logic shift_clk,
  output logic rxd
);
  // the line rests at mark level outside frames
  initial rxd = 1'h1;

  task automatic send(input logic [8:0] d, input int nd, input int per, input logic sb);
    rxd <= 1'h0;
    repeat (per) @(posedge aclk);
    for (int i = 0; i < nd; i++)
    begin
      rxd <= d[i];
      repeat (per) @(posedge aclk);
    end
    rxd <= sb;
    repeat (per) @(posedge aclk);
    rxd <= 1'h1;
    // idle gap keeps back-to-back frames apart by one bit time
    repeat (per) @(posedge aclk);
  endtask : send

  task automatic sync_send(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge shift_clk);
      rxd <= d[i];
    end
    @(posedge shift_clk);
    repeat (4) @(posedge aclk);
    // released line: show the inverse, never a stale level
    rxd <= ~d[7];
  endtask : sync_send
endmodule : sebg_rx_peer
`default_nettype wire

// ---- sebg_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module sebg_top_tb;
  import sebg_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [4:0] awaddr = 5'h0;
  logic [4:0] araddr = 5'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, rxd, sclk, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int mismatches = 0;
  int cmp_count = 0;

  always #10 aclk = ~aclk;

  sebg_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxd_in(rxd), .shift_clk_out(sclk), .irq(irq));

  sebg_rx_peer u_tx (.aclk(aclk), .shift_clk(sclk), .rxd(rxd));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input logic [31:0] lo, hi, got);
    cmp_count++;
    if ((got >= lo && got <= hi) !== 1'h1)
    begin
      mismatches++;
      $display("mismatch %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] er = SEBG_RESP_OK);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge aclk); while (awready !== 1'h1 || wready !== 1'h1);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er = SEBG_RESP_OK);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    rready <= 1'h0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
  endtask : rd

  task automatic rdc(input string what, input logic [4:0] a, input logic [31:0] exp, m);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d & m);
  endtask : rdc

  task automatic t_regs;
    logic [31:0] d;
    rdc("ctrl", SEBG_OFS_CTRL, 32'h0, 32'hFFFFFFFF);
    rdc("baud", SEBG_OFS_BAUD, 32'h0, 32'hFFFFFFFF);
    rdc("status", SEBG_OFS_STAT, 32'h0, 32'hFFFFFFFF);
    rd(5'h14, d, SEBG_RESP_ERR);
    chk("unmapped", 32'h0, d);
    wr(5'h14, 32'hFFFFFFFF, 4'hF, SEBG_RESP_ERR);
    wr(SEBG_OFS_CTRL, 32'h310);
    wr(SEBG_OFS_CTRL, 32'h0, 4'h2);
    rdc("strobe", SEBG_OFS_CTRL, 32'h010, 32'hFFFFFFFF);
  endtask : t_regs

  task automatic t_baud;
    logic [31:0] d1, d2;
    wr(SEBG_OFS_CTRL, 32'h0);
    wr(SEBG_OFS_BAUD, 32'hFFFFE005);
    rdc("stopped load", SEBG_OFS_BAUD, 32'h0, 32'hFFFFFFFF);
    wr(SEBG_OFS_CTRL, 32'h1);
    rd(SEBG_OFS_BAUD, d1);
    chk_rng("run load", 32'h0, 32'h5, d1);
    wr(SEBG_OFS_BAUD, 32'h1FFF);
    rd(SEBG_OFS_BAUD, d1);
    chk_rng("write load", 32'h1FF0, 32'h1FFF, d1);
    repeat (200) @(posedge aclk);
    rd(SEBG_OFS_BAUD, d2);
    chk_rng("rate", 32'd101, 32'd102, d1 - d2);
    wr(SEBG_OFS_CTRL, 32'h0);
    rd(SEBG_OFS_BAUD, d1);
    repeat (40) @(posedge aclk);
    rd(SEBG_OFS_BAUD, d2);
    chk("hold", d1, d2);
  endtask : t_baud

  // one frame check: status, data, flags still set after the read, irq masking, clear
  task automatic rx_case(input logic [31:0] c, b, input logic [8:0] d, input int nd, per, pre,
                         input logic sb, input logic [4:0] st, input logic [9:0] rx);
    wr(SEBG_OFS_CTRL, 32'h0);
    wr(SEBG_OFS_BAUD, b);
    wr(SEBG_OFS_CTRL, c);
    for (int i = 0; i <= pre; i++)
      u_tx.send(d, nd, per, sb);
    rdc("status", SEBG_OFS_STAT, {27'h0, st}, 32'h1F);
    rdc("rxdata", SEBG_OFS_RXD, {22'h0, rx}, 32'h2FF);
    rdc("sticky", SEBG_OFS_STAT, {27'h0, st}, 32'h1F);
    wr(SEBG_OFS_MASK, 32'h2);
    chk("irq", {31'h0, st[1]}, {31'h0, irq});
    wr(SEBG_OFS_STAT, 32'h1F);
    chk("irq off", 32'h0, {31'h0, irq});
    wr(SEBG_OFS_MASK, 32'h0);
  endtask : rx_case

  task automatic t_rate;
    rx_case(32'h65, 32'h1, 9'h0A5, 8, 64, 0, 1'h1, 5'h01, 10'h2A5);
    rx_case(32'h67, 32'h0, 9'h03C, 8, 48, 0, 1'h1, 5'h01, 10'h23C);
  endtask : t_rate

  task automatic t_errors;
    rx_case(32'h65, 32'h1, 9'h055, 8, 64, 0, 1'h0, 5'h07, 10'h255);
    rx_case(32'hA9, 32'h1, 9'h001, 9, 64, 0, 1'h1, 5'h0B, 10'h201);
    rx_case(32'hA9, 32'h1, 9'h101, 9, 64, 0, 1'h1, 5'h01, 10'h201);
    rx_case(32'hE9, 32'h1, 9'h1F0, 9, 64, 0, 1'h1, 5'h01, 10'h2F0);
    rx_case(32'h71, 32'h1, 9'h011, 8, 64, 1, 1'h1, 5'h13, 10'h211);
    rx_case(32'hA1, 32'h1, 9'h001, 9, 64, 1, 1'h0, 5'h01, 10'h201);
  endtask : t_errors

  task automatic t_sync;
    int lo, per;
    wr(SEBG_OFS_CTRL, 32'h0);
    wr(SEBG_OFS_BAUD, 32'h1);
    // the enabling write runs alongside, so the peer sees the very first shift clock fall
    fork
      u_tx.sync_send(8'hC3);
      wr(SEBG_OFS_CTRL, 32'h21);
      begin
        // the first low phase starts off the tick grid, so measure the second one
        @(negedge sclk);
        @(negedge sclk);
        lo = 0;
        do
        begin
          @(posedge aclk);
          #1;
          lo++;
        end
        while (sclk !== 1'h1);
        per = lo;
        do
        begin
          @(posedge aclk);
          #1;
          per++;
        end
        while (sclk !== 1'h0);
      end
    join
    // the byte completes on the fourth tick of the last bit, after the peer lets go
    repeat (16) @(posedge aclk);
    chk("shift low", 32'd8, lo);
    chk("shift period", 32'd16, per);
    rdc("sync data", SEBG_OFS_RXD, 32'h2C3, 32'h2FF);
    rdc("sync status", SEBG_OFS_STAT, 32'h01, 32'h1F);
    rdc("rx_en end", SEBG_OFS_CTRL, 32'h01, 32'h3FF);
    chk("shift idle", 32'h1, {31'h0, sclk});
  endtask : t_sync

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_baud();
    t_rate();
    t_errors();
    t_sync();
    wrap_up();
  end

  initial
  begin
    repeat (50000) @(posedge aclk);
    mismatches++;
    wrap_up();
  end
endmodule : sebg_top_tb
`default_nettype wire
